// File: rtl/lock_loop_clock_config.sv
// What this block does
// [RULE_01] Reference divided by 1, 2, 4 or 8 per bits 10:9.
// [RULE_02] Software keeps divided reference at or below 13.5MHz.
// [RULE_03] Control block runs at oscillator divided by one plus bits 8:6.
// [RULE_04] Output clock is oscillator divided by 2 to 256 per bits 5:3.
// [RULE_05] Feedback ratio from bits 2:0: 1, 2, 4, 8, or 16 for 1XX.
// [RULE_06] Software picks ratio 000 above 1MHz, 100 below 64 kHz.
// [RULE_07] Sixteen-bit fraction multiplier, MSB weighs one half, resets zero.
// [RULE_08] Ten-bit integer multiplier, unit LSB, resets zero.
// [RULE_09] With hold set, output clock keeps running if reference stops.
// [RULE_10] Software configures with a live reference, then sets hold.
// [RULE_11] Lock indication feeds the interrupt logic.
// [RULE_12] Lock indication can drive a general purpose pin.
// [RULE_13] Loop clock can drive a pin even if core uses another source.
// [RULE_14] Software selects loop output as core clock source when needed.
// [RULE_15] Software sets fractional mode for nonzero fraction.
// [RULE_16] Hold select at bit 3 of loop control, default 0.
// [RULE_17] Fractional mode enable at bit 2, 1 selects fractional.
// [RULE_18] Software keeps oscillator between 90 and 100 MHz.
// [RULE_19] Lock low while disabled; set only after lock is reached.
`default_nettype none
module lock_loop_clock_config
    import loop_clock_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    input wire logic ref_clock,
    output logic [1:0] ref_prescaler,
    output logic [2:0] loop_control_rate,
    output logic [2:0] output_divider,
    output logic [2:0] feedback_ratio,
    output logic [15:0] fraction_multiplier,
    output logic [9:0] integer_multiplier,
    output logic [3:0] loop_error_gain,
    output logic fractional_mode_enable,
    output logic core_clock_source_select,
    output logic loop_clock,
    output logic control_tick,
    output logic lock_pin_out,
    output logic clock_pin_out,
    output logic irq
);
    initial begin
        if (LOCK_WAIT < 1 || LOCK_WAIT > 65536) begin
            $error("lock_loop_clock_config: LOCK_WAIT out of range");
        end
    end

    // =========================================================
    // Registers
    // =========================================================
    logic [15:0] loop_control;
    logic [15:0] divider_control;
    logic [15:0] fraction_reg;
    logic [9:0] integer_reg;
    logic [1:0] pin_select;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    loop_state_t state;
    logic [15:0] lock_count;
    logic [7:0] loss_count;
    logic ref_d;
    logic ref_present;
    logic locked;

    // =========================================================
    // Decoding
    // =========================================================
    wire [7:0] index = address[ADDR_W-1:2];
    wire word_ok = (address[1:0] == 2'b00);
    wire sel_control = word_ok && (index == IDX_LOOP_CONTROL);
    wire sel_divider = word_ok && (index == IDX_DIVIDER_CONTROL);
    wire sel_fraction = word_ok && (index == IDX_FRACTION);
    wire sel_integer = word_ok && (index == IDX_INTEGER);
    wire sel_pins = word_ok && (index == IDX_PIN_SELECT);
    wire sel_status = word_ok && (index == IDX_IRQ_STATUS);
    wire sel_mask = word_ok && (index == IDX_IRQ_MASK);
    wire loop_enable = loop_control[ENABLE_BIT];
    wire freerun_hold = loop_control[HOLD_BIT]; // RULE_16
    wire [1:0] refdiv_code = divider_control[REFDIV_LSB +: 2];
    wire [2:0] rate_code = divider_control[RATE_LSB +: 3];
    wire [2:0] outdiv_code = divider_control[OUTDIV_LSB +: 3];
    wire [2:0] fratio_code = divider_control[FRATIO_LSB +: 3];

    logic [31:0] next_read;
    always_comb begin
        if (sel_control) begin
            next_read = {16'h0000, loop_control};
        end else if (sel_divider) begin
            next_read = {16'h0000, divider_control};
        end else if (sel_fraction) begin
            next_read = {16'h0000, fraction_reg};
        end else if (sel_integer) begin
            next_read = {22'h000000, integer_reg};
        end else if (sel_pins) begin
            next_read = {29'h00000000, locked, pin_select};
        end else if (sel_status) begin
            next_read = {29'h00000000, irq_status};
        end else if (sel_mask) begin
            next_read = {29'h00000000, irq_mask};
        end else begin
            next_read = 32'h00000000;
        end
    end

    // =========================================================
    // Register writes
    // =========================================================
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loop_control <= RESET_CONTROL; // RULE_16 RULE_17
            divider_control <= RESET_DIVIDER;
            fraction_reg <= RESET_FRACTION; // RULE_07
            integer_reg <= RESET_INTEGER; // RULE_08
            pin_select <= 2'h0;
            irq_mask <= '0;
            read_data <= 32'h00000000;
        end else begin
            if (write_strobe && sel_control) begin
                loop_control <= write_data[15:0];
            end
            if (write_strobe && sel_divider) begin
                divider_control <= write_data[15:0];
            end
            if (write_strobe && sel_fraction) begin
                fraction_reg <= write_data[15:0];
            end
            if (write_strobe && sel_integer) begin
                integer_reg <= write_data[INT_W-1:0];
            end
            if (write_strobe && sel_pins) begin
                pin_select <= write_data[1:0];
            end
            if (write_strobe && sel_mask) begin
                irq_mask <= write_data[IRQ_W-1:0];
            end
            read_data <= read_strobe ? next_read : 32'h00000000;
        end
    end

    // =========================================================
    // Reference presence detect
    // =========================================================
    // The reference is sampled as a synchronous input; a missing edge
    // for REF_LOSS_CYCLES marks it as gone.
    wire ref_edge = ref_clock ^ ref_d;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ref_d <= 1'b0;
            loss_count <= 8'h00;
            ref_present <= 1'b0;
        end else begin
            ref_d <= ref_clock;
            if (ref_edge) begin
                loss_count <= 8'h00;
                ref_present <= 1'b1;
            end else if (loss_count == 8'(REF_LOSS_CYCLES - 1)) begin
                ref_present <= 1'b0;
            end else begin
                loss_count <= loss_count + 8'h01;
            end
        end
    end

    // =========================================================
    // Lock sequencing
    // =========================================================
    wire ref_ok = ref_present || freerun_hold; // RULE_09
    wire lock_done = (lock_count == 16'(LOCK_WAIT - 1));
    wire cfg_write = write_strobe && (sel_divider || sel_fraction
        || sel_integer);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_OFF;
            lock_count <= 16'h0000;
            locked <= 1'b0;
        end else begin
            case (state)
                ST_OFF: begin
                    locked <= 1'b0;
                    lock_count <= 16'h0000;
                    if (loop_enable && ref_present) begin
                        state <= ST_ACQUIRE;
                    end
                end
                ST_ACQUIRE: begin
                    if (!loop_enable || !ref_present || cfg_write) begin
                        state <= ST_OFF;
                    end else if (lock_done) begin
                        state <= ST_LOCKED; // RULE_19
                        locked <= 1'b1;
                    end else begin
                        lock_count <= lock_count + 16'h0001;
                    end
                end
                ST_LOCKED: begin
                    if (!loop_enable || !ref_ok || cfg_write) begin
                        state <= ST_OFF; // RULE_19
                        locked <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_OFF;
                    locked <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // Dividers
    // =========================================================
    // The oscillator is modelled by the system clock, so every divider
    // below counts clock edges; the analogue loop itself lies outside.
    wire [15:0] ref_ratio = 16'h0001 << refdiv_code; // RULE_01
    wire [15:0] fb_ratio = fratio_code[2] ? 16'h0010
        : (16'h0001 << fratio_code[1:0]); // RULE_05
    wire [7:0] rate_term = {5'h00, rate_code}; // RULE_03
    wire [7:0] out_term = 8'((16'h0001 << outdiv_code) - 16'h0001); // RULE_04
    wire running = loop_enable && (ref_present || freerun_hold); // RULE_09
    logic rate_tick;

    pow2_divider #(.COUNT_W(8)) rate_div (
        .clock(clock),
        .reset_n(reset_n),
        .run(running),
        .terminal(rate_term),
        .tick(rate_tick),
        .clock_out()
    );

    logic out_clock;
    pow2_divider #(.COUNT_W(8)) out_div (
        .clock(clock),
        .reset_n(reset_n),
        .run(running),
        .terminal(out_term),
        .tick(),
        .clock_out(out_clock)
    );

    // =========================================================
    // Outputs and interrupts
    // =========================================================
    logic locked_d;
    wire ref_lost = (loss_count == 8'(REF_LOSS_CYCLES - 1)) & ~ref_edge
        & ref_present;
    wire [IRQ_W-1:0] events = {ref_lost, locked_d & ~locked,
        locked & ~locked_d}; // RULE_11
    wire [IRQ_W-1:0] clears = (write_strobe && sel_status)
        ? write_data[IRQ_W-1:0] : '0;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            locked_d <= 1'b0;
            irq_status <= '0;
            irq <= 1'b0;
            ref_prescaler <= 2'h0;
            loop_control_rate <= 3'h0;
            output_divider <= 3'h0;
            feedback_ratio <= 3'h0;
            fraction_multiplier <= 16'h0000;
            integer_multiplier <= 10'h000;
            loop_error_gain <= 4'h0;
            fractional_mode_enable <= 1'b0;
            core_clock_source_select <= 1'b0;
            loop_clock <= 1'b0;
            control_tick <= 1'b0;
            lock_pin_out <= 1'b0;
            clock_pin_out <= 1'b0;
        end else begin
            locked_d <= locked;
            irq_status <= (irq_status & ~clears) | events;
            irq <= |(((irq_status & ~clears) | events) & ~irq_mask);
            ref_prescaler <= refdiv_code[1:0] & ref_ratio[1:0]
                | refdiv_code; // RULE_01
            loop_control_rate <= rate_code; // RULE_03
            output_divider <= outdiv_code; // RULE_04
            feedback_ratio <= fb_ratio[4] ? 3'h4 : fratio_code; // RULE_05
            fraction_multiplier <= fraction_reg; // RULE_07
            integer_multiplier <= integer_reg; // RULE_08
            loop_error_gain <= loop_control[GAIN_LSB +: 4];
            fractional_mode_enable <= loop_control[FRAC_BIT]; // RULE_17
            core_clock_source_select <= loop_control[SOURCE_BIT];
            loop_clock <= out_clock; // RULE_09
            control_tick <= rate_tick; // RULE_03
            lock_pin_out <= pin_select[0] & locked; // RULE_12
            clock_pin_out <= pin_select[1] & out_clock; // RULE_13
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    lock_low_off_a: assert property (@(posedge clock) // RULE_19
        disable iff (!reset_n) !loop_enable |=> ##1 !locked)
        else $error("lock high while loop disabled");
    lock_pin_follow_a: assert property (@(posedge clock) // RULE_12
        disable iff (!reset_n) pin_select[0] |=> lock_pin_out == $past(locked))
        else $error("lock pin does not follow lock");
    lock_event_a: assert property (@(posedge clock) // RULE_11
        disable iff (!reset_n) $rose(locked) |=> irq_status[IRQ_LOCK])
        else $error("lock event not recorded");
    frac_out_a: assert property (@(posedge clock) // RULE_07
        disable iff (!reset_n) ##1 fraction_multiplier == $past(fraction_reg))
        else $error("fraction output mismatch");
    hold_keeps_lock_a: assert property (@(posedge clock) // RULE_09
        disable iff (!reset_n)
        (locked && freerun_hold && loop_enable && !cfg_write) |=> locked)
        else $error("lock lost while holding");
    ratio_top_a: assert property (@(posedge clock) // RULE_05
        disable iff (!reset_n) fratio_code[2] |=> feedback_ratio == 3'h4)
        else $error("ratio code 1XX not sixteen");
    int_out_a: assert property (@(posedge clock) // RULE_08
        disable iff (!reset_n) ##1 integer_multiplier == $past(integer_reg))
        else $error("integer output mismatch");
    clock_pin_a: assert property (@(posedge clock) // RULE_13
        disable iff (!reset_n) !pin_select[1] |=> !clock_pin_out)
        else $error("clock pin driven while not selected");
endmodule : lock_loop_clock_config
`default_nettype wire

// File: rtl/loop_clock_pkg.sv
`default_nettype none
package loop_clock_pkg;
    // =========================================================
    // Register indices (byte address is four times the index)
    // =========================================================
    localparam logic [7:0] IDX_LOOP_CONTROL = 8'h80;
    localparam logic [7:0] IDX_DIVIDER_CONTROL = 8'h81;
    localparam logic [7:0] IDX_FRACTION = 8'h82;
    localparam logic [7:0] IDX_INTEGER = 8'h83;
    localparam logic [7:0] IDX_PIN_SELECT = 8'h84;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h85;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h86;
    localparam int ADDR_W = 10;
    // =========================================================
    // Field positions
    // =========================================================
    localparam int ENABLE_BIT = 0;
    localparam int FRAC_BIT = 2;
    localparam int HOLD_BIT = 3;
    localparam int GAIN_LSB = 4;
    localparam int SOURCE_BIT = 8;
    localparam int REFDIV_LSB = 9;
    localparam int RATE_LSB = 6;
    localparam int OUTDIV_LSB = 3;
    localparam int FRATIO_LSB = 0;
    localparam int INT_W = 10;
    // =========================================================
    // Reset values and timing
    // =========================================================
    localparam logic [15:0] RESET_CONTROL = 16'h0000;
    localparam logic [15:0] RESET_DIVIDER = 16'h0000;
    localparam logic [15:0] RESET_FRACTION = 16'h0000;
    localparam logic [9:0] RESET_INTEGER = 10'h000;
    localparam int LOCK_TIME_NS = 2000;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int LOCK_CYCLES =
        (LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int REF_LOSS_CYCLES = 64;
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK = 0;
    localparam int IRQ_UNLOCK = 1;
    localparam int IRQ_REF_LOST = 2;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ACQUIRE = 3'b010,
        ST_LOCKED = 3'b100
    } loop_state_t;
endpackage : loop_clock_pkg
`default_nettype wire

// File: rtl/pow2_divider.sv
`default_nettype none
module pow2_divider
    import loop_clock_pkg::*;
#(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [COUNT_W-1:0] terminal,
    output logic tick,
    output logic clock_out
);
    // =========================================================
    // Counter
    // =========================================================
    logic [COUNT_W-1:0] count;
    wire at_end = (count >= terminal);
    wire [COUNT_W-1:0] next_count = at_end ? '0 : count + 1'b1;

    initial begin
        if (COUNT_W < 1 || COUNT_W > 16) begin
            $error("pow2_divider: COUNT_W out of range");
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            tick <= 1'b0;
            clock_out <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick <= 1'b0;
            clock_out <= 1'b0;
        end else begin
            count <= next_count;
            tick <= at_end;
            clock_out <= at_end ? ~clock_out : clock_out;
        end
    end
endmodule : pow2_divider
`default_nettype wire

// File: tb/ref_clock_source.sv
`default_nettype none
module ref_clock_source #(
    parameter int HALF_NS = 130
) (
    input wire logic run,
    output var logic ref_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // =========================================================
    // Reference source
    // =========================================================
    // Half period keeps the divided reference below 13.5MHz.
    // It runs only when asked and parks low when stopped, so losing the
    // reference looks like a real unplugged source.
    always begin
        if (run) begin
            #(HALF_NS) ref_out = ~ref_out;
        end else begin
            ref_out = 1'b0;
            @(run);
        end
    end
endmodule : ref_clock_source
`default_nettype wire

// File: tb/lock_loop_clock_config_tb.sv
`default_nettype none
module lock_loop_clock_config_tb import loop_clock_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, write_strobe, read_strobe, ref_run, ref_clock;
    logic [ADDR_W-1:0] address;
    logic [31:0] write_data, read_data, rd, r;
    logic [1:0] ref_prescaler;
    logic [2:0] loop_control_rate, output_divider, feedback_ratio;
    logic [15:0] fraction_multiplier;
    logic [9:0] integer_multiplier;
    logic [3:0] loop_error_gain;
    logic fractional_mode_enable, core_clock_source_select, loop_clock;
    logic control_tick, lock_pin_out, clock_pin_out, irq;
    int err_total, samples_checked, highs, rises;
    // =========================================================
    // Design and reference source
    // =========================================================
    lock_loop_clock_config #(.LOCK_WAIT(4)) dut (
        .clock(clock), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data),
        .ref_clock(ref_clock), .ref_prescaler(ref_prescaler),
        .loop_control_rate(loop_control_rate),
        .output_divider(output_divider), .feedback_ratio(feedback_ratio),
        .fraction_multiplier(fraction_multiplier),
        .integer_multiplier(integer_multiplier),
        .loop_error_gain(loop_error_gain),
        .fractional_mode_enable(fractional_mode_enable),
        .core_clock_source_select(core_clock_source_select),
        .loop_clock(loop_clock), .control_tick(control_tick),
        .lock_pin_out(lock_pin_out), .clock_pin_out(clock_pin_out),
        .irq(irq));
    ref_clock_source #(.HALF_NS(130)) partner (.run(ref_run),
        .ref_out(ref_clock));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [2:0] ratio_out(input logic [2:0] c);
        return c[2] ? 3'h4 : c;
    endfunction : ratio_out
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, expected, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic reg_write(input logic [7:0] idx, input logic [31:0] d);
        @(posedge clock);
        write_strobe <= 1'b1;
        address <= {idx, 2'b00};
        write_data <= d;
        @(posedge clock);
        write_strobe <= 1'b0;
        // Field copies trail the register by one edge, so wait for them.
        @(posedge clock);
        @(negedge clock);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] idx, output logic [31:0] d);
        @(posedge clock);
        read_strobe <= 1'b1;
        address <= {idx, 2'b00};
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        d = read_data;
    endtask : reg_read
    task automatic wait_lock(input logic want);
        for (int i = 0; i < 400 && lock_pin_out !== want; i++) begin
            @(negedge clock);
        end
        check("lock pin", {31'h0, lock_pin_out}, {31'h0, want});
        if (lock_pin_out !== want) complete_run();
    endtask : wait_lock
    // Rising edges are counted over whole periods, so the start phase
    // of the window cannot change the count.
    task automatic count(input int n);
        logic prev_clk;
        highs = 0;
        rises = 0;
        prev_clk = loop_clock;
        repeat (n) begin
            @(negedge clock);
            highs += (control_tick === 1'b1);
            rises += (loop_clock === 1'b1 && prev_clk === 1'b0);
            prev_clk = loop_clock;
        end
    endtask : count
    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        reset_n = 1'b0;
        {write_strobe, read_strobe, ref_run} = 3'b000;
        address = '0;
        write_data = 32'h0000_0000;
        err_total = 0;
        samples_checked = 0;
        r = $urandom(32'h7a0e);
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        check("irq after reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            reg_read(IDX_LOOP_CONTROL + 8'(i), rd);
            check("reset value", rd, 32'h0);
        end
        reg_write(8'h90, 32'hFFFF_FFFF);
        reg_read(8'h90, rd);
        check("unmapped read", rd, 32'h0);
        repeat (4) begin
            r = $urandom();
            reg_write(IDX_FRACTION, r);
            check("fraction out", {16'h0, fraction_multiplier},
                  {16'h0, r[15:0]});
            reg_read(IDX_FRACTION, rd);
            check("fraction read", rd, {16'h0, r[15:0]});
            reg_write(IDX_INTEGER, r);
            check("integer out", {22'h0, integer_multiplier},
                  {22'h0, r[9:0]});
            reg_read(IDX_INTEGER, rd);
            check("integer read", rd, {22'h0, r[9:0]});
        end
        // Twenty-five times a reference near 3.85MHz puts the oscillator
        // near 96MHz.
        reg_write(IDX_INTEGER, 32'h19);
        reg_write(IDX_PIN_SELECT, 32'h3);
        ref_run = 1'b1;
        repeat (100) @(negedge clock);
        check("lock while off", {31'h0, lock_pin_out}, 32'h0);
        reg_write(IDX_LOOP_CONTROL, 32'h5);
        check("frac mode", {31'h0, fractional_mode_enable}, 32'h1);
        check("core source", {31'h0, core_clock_source_select}, 32'h0);
        wait_lock(1'b1);
        repeat (2) @(negedge clock);
        reg_read(IDX_IRQ_STATUS, rd);
        check("lock event", rd & 32'h1, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        reg_write(IDX_IRQ_MASK, 32'h7);
        check("irq masked", {31'h0, irq}, 32'h0);
        reg_write(IDX_IRQ_MASK, 32'h0);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        reg_write(IDX_IRQ_STATUS, 32'h7);
        reg_read(IDX_IRQ_STATUS, rd);
        check("status cleared", rd, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        repeat (20) begin
            @(negedge clock);
            check("clock pin", {31'h0, clock_pin_out},
                  {31'h0, loop_clock});
        end
        // Every three-bit divider code is set once, each prescaler code twice; the field values ride along.
        for (int i = 0; i < 8; i++) begin
            r = {$urandom() & 32'hFFFF_F800} | {21'h0, 2'(i), 3'(i), 3'(i),
                3'(i)};
            reg_write(IDX_DIVIDER_CONTROL, r);
            check("prescaler", {30'h0, ref_prescaler},
                  {30'h0, r[10:9]});
            check("rate", {29'h0, loop_control_rate},
                  {29'h0, r[8:6]});
            check("out divider", {29'h0, output_divider},
                  {29'h0, r[5:3]});
            check("ratio", {29'h0, feedback_ratio},
                  {29'h0, ratio_out(r[2:0])});
            repeat (300) @(negedge clock);
            count(840);
            check("tick count", highs, 840 / (i + 1));
            count(512);
            check("loop clock rises", rises, 512 >> (i + 1));
        end
        reg_write(IDX_DIVIDER_CONTROL, 32'h10);
        wait_lock(1'b1);
        reg_write(IDX_LOOP_CONTROL, 32'hD);
        ref_run = 1'b0;
        repeat (200) @(negedge clock);
        check("hold lock", {31'h0, lock_pin_out}, 32'h1);
        count(64);
        check("hold clock", rises, 8);
        reg_write(IDX_IRQ_STATUS, 32'h7);
        reg_write(IDX_LOOP_CONTROL, 32'h5);
        wait_lock(1'b0);
        repeat (2) @(negedge clock);
        reg_read(IDX_IRQ_STATUS, rd);
        check("unlock event", rd & 32'h2, 32'h2);
        check("irq unlock", {31'h0, irq}, 32'h1);
        reg_write(IDX_LOOP_CONTROL, 32'h1A5);
        check("core source", {31'h0, core_clock_source_select}, 32'h1);
        check("gain", {28'h0, loop_error_gain}, 32'hA);
        complete_run();
    end
endmodule : lock_loop_clock_config_tb
`default_nettype wire
